/* File: rtl/wake_frame_mask_dlc_regs.sv */
// Identifier mask, length code and payload byte seven registers of the
// selective-wake filter, plus the configuration-valid flag and the
// registered match result of the wake frame comparator.
// Assumes register accesses arrive already decoded from the serial port,
// one cycle wide, and that frame fields are presented with i_rx_valid.
`include "wake_regs_cfg.svh"

module wake_frame_mask_dlc_regs (
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_soft_rst,
   input  wire logic                   i_reg_wr,
   input  wire logic                   i_reg_rd,
   input  wire wake_regs_pkg::reg_addr_t i_reg_addr,
   input  wire wake_regs_pkg::reg_byte_t i_reg_wdata,
   input  wire logic                   i_cfg_valid_set,
   input  wire logic                   i_other_cfg_wr,
   input  wire logic                   i_stop_mode,
   input  wire logic                   i_wake_event,
   input  wire wake_regs_pkg::reg_byte_t i_mask_id_top,
   input  wire wake_regs_pkg::can_id_t   i_cfg_id,
   input  wire logic                   i_rx_valid,
   input  wire wake_regs_pkg::can_id_t   i_rx_id,
   input  wire wake_regs_pkg::len_code_t i_rx_code,
   output logic                        o_config_valid,
   output wake_regs_pkg::reg_byte_t    o_reg_rdata,
   output wake_regs_pkg::reg_byte_t    o_payload_byte_seven,
   output wake_regs_pkg::len_code_t    o_length_code,
   output wake_regs_pkg::len_code_t    o_payload_len,
   output wake_regs_pkg::can_id_t      o_id_mask,
   output logic                        o_id_match,
   output logic                        o_wake_hit
);
   import wake_regs_pkg::*;

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   reg_byte_t id_mask_upper_byte;
   reg_byte_t id_mask_middle_byte;
   logic [4:0] id_mask_low_bits;
   len_code_t length_code;

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   wire logic sel_hi  = (i_reg_addr == `ADDR_ID_MASK_HI);
   wire logic sel_mid = (i_reg_addr == `ADDR_ID_MASK_MID);
   wire logic sel_lo  = (i_reg_addr == `ADDR_ID_MASK_LO);
   wire logic sel_len = (i_reg_addr == `ADDR_LENGTH_CODE);
   wire logic sel_b7  = (i_reg_addr == `ADDR_PAYLOAD_B7);
   wire logic in_bank = sel_hi | sel_mid | sel_lo | sel_len | sel_b7;
   wire logic bank_wr = i_reg_wr & in_bank;

   // Read mux; reserved positions are constant zero
   reg_byte_t next_rdata;
   assign next_rdata =
      sel_hi  ? id_mask_upper_byte :
      sel_mid ? id_mask_middle_byte :
      sel_lo  ? {1'b0, id_mask_low_bits, 2'b00} :
      sel_len ? {4'h0, length_code} :
      sel_b7  ? o_payload_byte_seven : `RST_BYTE;

   // Decoded payload length: any code with the top bit set means eight
   len_code_t next_len;
   assign next_len = length_code[`LEN_FULL_BIT] ?
                     `LEN_FULL_BYTES : length_code;

   // Full 29-bit mask vector as seen by the comparator
   can_id_t next_mask;
   assign next_mask = {i_mask_id_top, id_mask_upper_byte,
                       id_mask_middle_byte, id_mask_low_bits};

   // Any change of wake configuration, or any config write in stop
   wire logic stop_wr   = i_stop_mode & (i_other_cfg_wr | bank_wr);
   wire logic cfg_clear = bank_wr | stop_wr | i_wake_event;

   // -----------------------------------------------------------------
   // Comparator hookup
   // -----------------------------------------------------------------
   wake_match_if mif ();
   assign mif.rx_id    = i_rx_id;
   assign mif.cfg_id   = i_cfg_id;  // Standard ids live in 28..18
   assign mif.mask     = o_id_mask;
   assign mif.rx_code  = i_rx_code;
   assign mif.cfg_code = length_code;

   wake_id_matcher u_matcher (
      .m (mif.matcher)
   );

   wire logic frame_ok = i_rx_valid & mif.id_hit & mif.code_hit;

   // -----------------------------------------------------------------
   // Mask registers
   // -----------------------------------------------------------------
   // Power-on and soft reset both bring the masks to zero
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         id_mask_upper_byte  <= `RST_BYTE;
         id_mask_middle_byte <= `RST_BYTE;
         id_mask_low_bits    <= `RST_LO_MASK;
      end else if (i_soft_rst) begin
         id_mask_upper_byte  <= `RST_BYTE;
         id_mask_middle_byte <= `RST_BYTE;
         id_mask_low_bits    <= `RST_LO_MASK;
      end else if (i_reg_wr) begin
         if (sel_hi)  id_mask_upper_byte  <= i_reg_wdata;
         if (sel_mid) id_mask_middle_byte <= i_reg_wdata;
         if (sel_lo)  id_mask_low_bits    <=
            i_reg_wdata[`LO_MASK_MSB:`LO_MASK_LSB];
      end
   end

   // -----------------------------------------------------------------
   // Length code and payload byte
   // -----------------------------------------------------------------
   // Only the low nibble is stored, so the upper bits cannot stick
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         length_code          <= `RST_LEN_CODE;
         o_payload_byte_seven <= `RST_BYTE;
      end else if (i_soft_rst) begin
         length_code          <= `RST_LEN_CODE;
         o_payload_byte_seven <= `RST_BYTE;
      end else if (i_reg_wr) begin
         if (sel_len) length_code <=
            i_reg_wdata[`LEN_CODE_MSB:0];
         if (sel_b7)  o_payload_byte_seven <= i_reg_wdata;
      end
   end

   // -----------------------------------------------------------------
   // Configuration-valid flag
   // -----------------------------------------------------------------
   // Clear wins over a same-cycle set: a half-changed setup never arms
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_config_valid <= 1'b0;
      else if (i_soft_rst | cfg_clear)
         o_config_valid <= 1'b0;
      else if (i_cfg_valid_set)
         o_config_valid <= 1'b1;
   end

   // -----------------------------------------------------------------
   // Registered outputs
   // -----------------------------------------------------------------
   // Copies lag their source by one cycle, keeping outputs flop-driven
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata   <= `RST_BYTE;
         o_length_code <= `RST_LEN_CODE;
         o_payload_len <= `RST_LEN_CODE;
         o_id_mask     <= '0;
         o_id_match    <= 1'b0;
         o_wake_hit    <= 1'b0;
      end else begin
         if (i_reg_rd) o_reg_rdata <= next_rdata;
         o_length_code <= length_code;
         o_payload_len <= next_len;
         o_id_mask     <= next_mask;
         o_id_match    <= frame_ok;
         o_wake_hit    <= frame_ok & o_config_valid;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   sequence plain_write(logic sel);
      i_reg_wr && sel && !i_soft_rst;
   endsequence

   sequence bank_change;
      bank_wr ##1 1'b1;
   endsequence

   chk_hi_write: assert property (
      plain_write(sel_hi) |=> id_mask_upper_byte == $past(i_reg_wdata))
      else $error("upper mask byte not written");

   chk_mid_write: assert property (
      plain_write(sel_mid) |=> ##1 o_id_mask[12:5] == $past(i_reg_wdata, 2))
      else $error("middle mask not seen by comparator");

   chk_lo_field: assert property (
      plain_write(sel_lo) |=> ##1
         o_id_mask[4:0] == $past(i_reg_wdata[6:2], 2))
      else $error("low mask field misplaced");

   chk_rsvd_zero: assert property (
      i_reg_rd && (sel_lo || sel_len) |=>
         o_reg_rdata[7] == 1'b0 &&
         ($past(sel_lo) ? o_reg_rdata[1:0] == 2'b00
                        : o_reg_rdata[7:4] == 4'h0))
      else $error("reserved bits read nonzero");

   chk_soft_clear: assert property (
      i_soft_rst |=> id_mask_upper_byte == 8'h00 &&
         id_mask_middle_byte == 8'h00 && length_code == 4'h0)
      else $error("soft reset left state behind");

   chk_len_decode: assert property (
      plain_write(sel_len) |=> ##1 o_payload_len ==
         ($past(i_reg_wdata[3], 2) ? 4'h8 : $past(i_reg_wdata[3:0], 2)))
      else $error("payload length decode wrong");

   chk_match_cause: assert property (
      o_id_match |-> $past(i_rx_valid) &&
         $past(i_rx_code) == $past(length_code) &&
         (($past(i_rx_id) ^ $past(i_cfg_id)) & $past(o_id_mask))
            == 29'h0000_0000)
      else $error("match without full agreement");

   // Converse: an agreeing frame must never be dropped
   chk_match_seen: assert property (
      i_rx_valid && i_rx_code == length_code &&
         ((i_rx_id ^ i_cfg_id) & o_id_mask) == 29'h0000_0000
         |=> o_id_match)
      else $error("agreeing frame not matched");

   chk_bank_clear: assert property (
      bank_change |-> !o_config_valid)
      else $error("valid flag survived config write");

   chk_stop_clear: assert property (
      i_stop_mode && i_other_cfg_wr |=> !o_config_valid)
      else $error("stop mode write kept valid flag");

   chk_wake_gate: assert property (
      o_wake_hit |-> $past(o_config_valid) && o_id_match)
      else $error("wake hit without valid setup");

   chk_byte7_write: assert property (
      plain_write(sel_b7) |=> o_payload_byte_seven == $past(i_reg_wdata))
      else $error("payload byte seven not written");
endmodule : wake_frame_mask_dlc_regs

/* File: rtl/wake_regs_cfg.svh */
// Offsets, field positions and reset values of the wake-frame mask bank.
// Assumes a 7-bit register address as decoded from the serial frame.
`ifndef WAKE_REGS_CFG_SVH
`define WAKE_REGS_CFG_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define ADDR_ID_MASK_HI   7'h28
`define ADDR_ID_MASK_MID  7'h29
`define ADDR_ID_MASK_LO   7'h2A
`define ADDR_LENGTH_CODE  7'h2B
`define ADDR_PAYLOAD_B7   7'h2C

// -----------------------------------------------------------------
// Field layout and reset values
// -----------------------------------------------------------------
`define LO_MASK_MSB       6
`define LO_MASK_LSB       2
`define LEN_CODE_MSB      3
`define LEN_FULL_BIT      3
`define LEN_FULL_BYTES    4'h8
`define RST_BYTE          8'h00
`define RST_LO_MASK       5'h00
`define RST_LEN_CODE      4'h0

`endif

/* File: rtl/wake_regs_pkg.sv */
// Types shared by the wake-frame mask bank and its identifier matcher.
// Assumes nothing of its surroundings.
package wake_regs_pkg;
   typedef logic [7:0]  reg_byte_t;
   typedef logic [6:0]  reg_addr_t;
   typedef logic [3:0]  len_code_t;
   typedef logic [28:0] can_id_t;
endpackage : wake_regs_pkg

/* File: rtl/wake_match_if.sv */
// Carrier between the mask bank and its identifier matcher.
// Assumes the matcher is purely combinational.
interface wake_match_if;
   import wake_regs_pkg::*;
   can_id_t   rx_id;
   can_id_t   cfg_id;
   can_id_t   mask;
   len_code_t rx_code;
   len_code_t cfg_code;
   logic      id_hit;
   logic      code_hit;
   modport matcher (input rx_id, cfg_id, mask, rx_code, cfg_code,
                    output id_hit, code_hit);
   modport bank    (output rx_id, cfg_id, mask, rx_code, cfg_code,
                    input id_hit, code_hit);
endinterface : wake_match_if

/* File: rtl/wake_id_matcher.sv */
// Masked identifier and length-code comparator.
// Assumes the bank registers its results; this block is combinational.
module wake_id_matcher (
   wake_match_if.matcher m
);
   import wake_regs_pkg::*;

   // -----------------------------------------------------------------
   // Per-bit compare: a clear mask bit makes the bit a don't-care
   // -----------------------------------------------------------------
   can_id_t bit_ok;
   genvar   i;
   generate
      for (i = 0; i < 29; i = i + 1) begin : g_bit
         assign bit_ok[i] = ~m.mask[i] | (m.rx_id[i] == m.cfg_id[i]);
      end
   endgenerate

   // All four code bits must agree, not just the decoded length
   assign m.id_hit   = &bit_ok;
   assign m.code_hit = (m.rx_code == m.cfg_code);
endmodule : wake_id_matcher

/* File: bench/wake_host_model.sv */
// Host side of the bank's decoded register port: byte writes and reads.
// Assumes the bank samples its strobes on the rising clock edge.
module wake_host_model (
   input  wire logic                    i_core_clk,
   input  wire wake_regs_pkg::reg_byte_t i_reg_rdata,
   output logic                         o_reg_wr,
   output logic                         o_reg_rd,
   output wake_regs_pkg::reg_addr_t     o_reg_addr,
   output wake_regs_pkg::reg_byte_t     o_reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   import wake_regs_pkg::*;

   initial begin
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_addr  = 7'h00;
      o_reg_wdata = 8'h00;
   end

   // One-cycle strobe, then one idle cycle; idle bus shows inverted values, not stale ones
   task automatic access(input logic wr, input reg_addr_t a,
                         input reg_byte_t d);
      @(negedge i_core_clk);
      o_reg_wr    = wr;
      o_reg_rd    = ~wr;
      o_reg_addr  = a;
      o_reg_wdata = d;
      @(negedge i_core_clk);
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_addr  = ~a;
      o_reg_wdata = ~d;
   endtask : access

   // Read data lands one edge after the strobe
   task automatic read(input reg_addr_t a, output reg_byte_t d);
      access(1'b0, a, 8'h00);
      d = i_reg_rdata;
   endtask : read

   // Standard identifier placed in identifier bits 28..18
   function automatic can_id_t std_id(input logic [10:0] s);
      return {s, 18'h0_0000};
   endfunction : std_id
endmodule : wake_host_model

/* File: bench/test_wake_frame_mask_dlc_regs.sv */
// Self-checking bench for the wake-frame mask, length and byte-7 bank.
// Assumes the host model drives the register port; all else from here.
`include "wake_regs_cfg.svh"
module test_wake_frame_mask_dlc_regs;
   timeunit 1ns;
   timeprecision 1ns;
   import wake_regs_pkg::*;
   logic      i_core_clk, i_rst_n, i_soft_rst, i_reg_wr, i_reg_rd;
   logic      i_cfg_valid_set, i_other_cfg_wr, i_stop_mode, i_wake_event;
   logic      i_rx_valid, o_config_valid, o_id_match, o_wake_hit;
   reg_addr_t i_reg_addr;
   reg_byte_t i_reg_wdata, i_mask_id_top, o_reg_rdata, o_payload_byte_seven;
   can_id_t   i_cfg_id, i_rx_id, o_id_mask;
   len_code_t i_rx_code, o_length_code, o_payload_len;
   reg_byte_t rd;
   int        mismatches  = 0;
   int        check_count = 0;

   wake_frame_mask_dlc_regs u_wake_frame_mask_dlc_regs (
      .i_core_clk           (i_core_clk),
      .i_rst_n              (i_rst_n),
      .i_soft_rst           (i_soft_rst),
      .i_reg_wr             (i_reg_wr),
      .i_reg_rd             (i_reg_rd),
      .i_reg_addr           (i_reg_addr),
      .i_reg_wdata          (i_reg_wdata),
      .i_cfg_valid_set      (i_cfg_valid_set),
      .i_other_cfg_wr       (i_other_cfg_wr),
      .i_stop_mode          (i_stop_mode),
      .i_wake_event         (i_wake_event),
      .i_mask_id_top        (i_mask_id_top),
      .i_cfg_id             (i_cfg_id),
      .i_rx_valid           (i_rx_valid),
      .i_rx_id              (i_rx_id),
      .i_rx_code            (i_rx_code),
      .o_config_valid       (o_config_valid),
      .o_reg_rdata          (o_reg_rdata),
      .o_payload_byte_seven (o_payload_byte_seven),
      .o_length_code        (o_length_code),
      .o_payload_len        (o_payload_len),
      .o_id_mask            (o_id_mask),
      .o_id_match           (o_id_match),
      .o_wake_hit           (o_wake_hit)
   );
   wake_host_model u_wake_host_model (.i_core_clk(i_core_clk),
      .i_reg_rdata(o_reg_rdata), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
      .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));

   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end

   task automatic chk(input string n, input can_id_t seen, exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done

   task automatic wr(input reg_addr_t a, input reg_byte_t d);
      u_wake_host_model.access(1'b1, a, d);
      @(negedge i_core_clk); // Copies trail storage by one edge
   endtask : wr

   task automatic rdchk(input reg_addr_t a, input reg_byte_t e);
      u_wake_host_model.read(a, rd);
      chk("rdata", rd, e);
   endtask : rdchk

   task automatic pulse(ref logic s);
      @(negedge i_core_clk);
      s = 1'b1;
      @(negedge i_core_clk);
      s = 1'b0;
   endtask : pulse

   task automatic frame(input can_id_t id, input len_code_t c,
                        input logic m, h);
      @(negedge i_core_clk);
      {i_rx_valid, i_rx_id, i_rx_code} = {1'b1, id, c};
      @(negedge i_core_clk);
      i_rx_valid = 1'b0;
      chk("id_match", o_id_match, m);
      chk("wake_hit", o_wake_hit, h);
   endtask : frame

   task automatic t_reset_vals();
      for (int a = 'h28; a <= 'h2C; a++) rdchk(a[6:0], 8'h00);
      rdchk(7'h3F, 8'h00);
      $display("reset values done");
   endtask : t_reset_vals

   task automatic t_fields();
      wr(`ADDR_ID_MASK_HI, 8'hA5);
      wr(`ADDR_ID_MASK_MID, 8'h5A);
      wr(`ADDR_ID_MASK_LO, 8'hFF);
      wr(`ADDR_LENGTH_CODE, 8'hFA);
      wr(`ADDR_PAYLOAD_B7, 8'hC3);
      wr(7'h3F, 8'hFF);
      chk("id_mask", o_id_mask, {8'h81, 8'hA5, 8'h5A, 5'h1F});
      rdchk(`ADDR_ID_MASK_LO, 8'h7C);
      rdchk(`ADDR_LENGTH_CODE, 8'h0A);
      rdchk(`ADDR_PAYLOAD_B7, 8'hC3);
      chk("byte7", o_payload_byte_seven, 8'hC3);
      for (int c = 0; c < 16; c++) begin
         wr(`ADDR_LENGTH_CODE, {4'h0, c[3:0]});
         chk("code", o_length_code, c[3:0]);
         chk("len", o_payload_len, (c > 7) ? 4'h8 : c[3:0]);
      end
      $display("fields done");
   endtask : t_fields

   task automatic t_compare();
      i_mask_id_top = 8'hFF;
      i_cfg_id = u_wake_host_model.std_id(11'h5A3) | 29'h0000_0015;
      wr(`ADDR_ID_MASK_HI, 8'hFF);
      wr(`ADDR_ID_MASK_MID, 8'h00);
      wr(`ADDR_ID_MASK_LO, 8'h7C);
      wr(`ADDR_LENGTH_CODE, 8'h09);
      frame(i_cfg_id, 4'h9, 1'b1, 1'b0);
      frame(i_cfg_id ^ 29'h0000_1FE0, 4'h9, 1'b1, 1'b0);
      frame(i_cfg_id ^ 29'h0000_2000, 4'h9, 1'b0, 1'b0);
      frame(i_cfg_id ^ 29'h0000_0001, 4'h9, 1'b0, 1'b0);
      frame(i_cfg_id, 4'hA, 1'b0, 1'b0);
      pulse(i_cfg_valid_set);
      frame(i_cfg_id, 4'h9, 1'b1, 1'b1);
      $display("compare done");
   endtask : t_compare

   task automatic t_flag();
      chk("flag", o_config_valid, 1'b1);
      wr(`ADDR_PAYLOAD_B7, 8'h11);
      chk("flag", o_config_valid, 1'b0);
      pulse(i_cfg_valid_set);
      pulse(i_other_cfg_wr);
      chk("flag", o_config_valid, 1'b1);
      i_stop_mode = 1'b1;
      pulse(i_other_cfg_wr);
      chk("flag", o_config_valid, 1'b0);
      i_stop_mode = 1'b0;
      pulse(i_cfg_valid_set);
      pulse(i_wake_event);
      chk("flag", o_config_valid, 1'b0);
      pulse(i_cfg_valid_set);
      pulse(i_soft_rst);
      chk("flag", o_config_valid, 1'b0);
      rdchk(`ADDR_ID_MASK_HI, 8'h00);
      rdchk(`ADDR_LENGTH_CODE, 8'h00);
      chk("id_mask", o_id_mask, {8'hFF, 21'h00_0000});
      $display("flag done");
   endtask : t_flag

   initial begin
      {i_rst_n, i_soft_rst, i_cfg_valid_set, i_other_cfg_wr} = 4'h0;
      {i_stop_mode, i_wake_event, i_rx_valid} = 3'h0;
      {i_rx_id, i_cfg_id, i_rx_code} = '0;
      i_mask_id_top = 8'h81;
      repeat (2) @(negedge i_core_clk);
      i_rst_n = 1'b1;
      t_reset_vals();
      t_fields();
      t_compare();
      t_flag();
      test_done();
   end

   // Whole run is well under 400 cycles
   initial begin
      #200000;
      mismatches++;
      test_done();
   end
endmodule : test_wake_frame_mask_dlc_regs
